// ---- core/rcs_pkg.sv ----
// constants for the reset and clock start-up control block
package rcs_pkg;
  // ---------------------------------------------------------------
  // register map (word aligned byte addresses)
  // ---------------------------------------------------------------
  localparam logic [3:0] RCS_ADDR_RUNRST = 4'h0;
  localparam logic [3:0] RCS_ADDR_PLL = 4'h4;
  localparam logic [3:0] RCS_ADDR_STATUS = 4'h8;
  localparam logic [3:0] RCS_ADDR_VECTOR = 4'hC;
  localparam int RCS_RUNRST_EN_BIT = 0;
  localparam int RCS_PLL_MUL_LSB = 0;
  localparam int RCS_PLL_DIV_LSB = 8;
  // ---------------------------------------------------------------
  // ratio codes and timing
  // ---------------------------------------------------------------
  localparam logic [7:0] RCS_MUL_8 = 8'h08;
  localparam logic [7:0] RCS_MUL_32 = 8'h20;
  localparam logic [7:0] RCS_MUL_16 = 8'h10;
  localparam logic [7:0] RCS_DIV_RESET = 8'h01;
  localparam logic [31:0] RCS_RESET_VECTOR = 32'h0008_0004;
  localparam int RCS_LOCK_CYCLES = 4096;
  localparam int RCS_LOCK_W = 13;
  typedef enum logic [1:0] {
    RCS_ST_RESET = 2'b00,
    RCS_ST_LOCK = 2'b01,
    RCS_ST_RUN = 2'b11
  } rcs_state_t;
endpackage

// ---- core/rcs_top.sv ----
// reset and clock start-up control with wishbone registers
`timescale 1ns/10ps
module rcs_top #(
  parameter int LOCK_CYCLES = rcs_pkg::RCS_LOCK_CYCLES
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic hw_reset_n_i,
  input wire logic [1:0] clk_ratio_strap_i,
  input wire logic [2:0] boot_mode_strap_i,
  input wire logic rst_pin_i,
  output logic rst_pin_o,
  output logic rst_pin_oe_o,
  output logic core_reset_o,
  output logic running_reset_o,
  output logic [31:0] fetch_addr_o,
  output logic fetch_start_o,
  output logic [7:0] pll_mul_o,
  output logic [7:0] pll_div_o,
  output logic [2:0] boot_mode_o,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [3:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o
);
  import rcs_pkg::*;

  rcs_state_t state_reg;
  logic [RCS_LOCK_W-1:0] lock_cnt_reg;
  logic in_reset;
  logic lock_done;
  logic wb_req;
  logic wr_runrst;
  logic wr_pll;
  logic [7:0] strap_mul;

  assign in_reset = rst_i || !hw_reset_n_i;
  assign lock_done = lock_cnt_reg == RCS_LOCK_W'(LOCK_CYCLES - 1);
  assign wb_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign wr_runrst = wb_req && wb_we_i && wb_sel_i[0]
                     && wb_adr_i == RCS_ADDR_RUNRST;
  assign wr_pll = wb_req && wb_we_i && state_reg == RCS_ST_RUN
                  && wb_adr_i == RCS_ADDR_PLL;

  // ---------------------------------------------------------------
  // strap decode
  // ---------------------------------------------------------------
  // reserved code falls back to the slowest safe ratio
  always_comb begin
    unique case (clk_ratio_strap_i)
      2'b00: strap_mul = RCS_MUL_8;
      2'b01: strap_mul = RCS_MUL_32;
      2'b10: strap_mul = RCS_MUL_16;
      2'b11: strap_mul = RCS_MUL_8;
    endcase
  end

  // ---------------------------------------------------------------
  // start-up sequencer
  // ---------------------------------------------------------------
  // lock counter runs on the reference clock, cleared in reset
  always_ff @(posedge clk_i) begin
    if (in_reset) begin
      state_reg <= RCS_ST_RESET;
      lock_cnt_reg <= '0;
    end else begin
      unique case (state_reg)
        RCS_ST_RESET: state_reg <= RCS_ST_LOCK;
        RCS_ST_LOCK: begin
          lock_cnt_reg <= lock_cnt_reg + 1'b1;
          if (lock_done) begin
            state_reg <= RCS_ST_RUN;
          end
        end
        RCS_ST_RUN: state_reg <= RCS_ST_RUN;
        default: state_reg <= RCS_ST_RESET;
      endcase
    end
  end

  // core release and vector fetch
  always_ff @(posedge clk_i) begin
    if (in_reset) begin
      core_reset_o <= 1'b1;
      fetch_start_o <= 1'b0;
      fetch_addr_o <= RCS_RESET_VECTOR;
    end else begin
      fetch_start_o <= state_reg == RCS_ST_LOCK && lock_done;
      if (state_reg == RCS_ST_LOCK && lock_done) begin
        core_reset_o <= 1'b0;
      end
      fetch_addr_o <= RCS_RESET_VECTOR;
    end
  end

  // boot straps and clock ratio caught while held in hardware reset
  always_ff @(posedge clk_i) begin
    if (!hw_reset_n_i) begin
      boot_mode_o <= boot_mode_strap_i;
      pll_mul_o <= strap_mul;
      pll_div_o <= RCS_DIV_RESET;
    end else if (rst_i) begin
      pll_mul_o <= RCS_MUL_8;
      pll_div_o <= RCS_DIV_RESET;
      boot_mode_o <= 3'h0;
    end else if (wr_pll) begin
      if (wb_sel_i[0]) begin
        pll_mul_o <= wb_dat_i[RCS_PLL_MUL_LSB +: 8];
      end
      if (wb_sel_i[1]) begin
        pll_div_o <= wb_dat_i[RCS_PLL_DIV_LSB +: 8];
      end
    end
  end

  // ---------------------------------------------------------------
  // shared reset pin
  // ---------------------------------------------------------------
  // output by default, running-reset input when enabled
  always_ff @(posedge clk_i) begin
    if (in_reset) begin
      rst_pin_oe_o <= 1'b1;
      rst_pin_o <= 1'b0;
      running_reset_o <= 1'b0;
    end else begin
      if (wr_runrst) begin
        rst_pin_oe_o <= !wb_dat_i[RCS_RUNRST_EN_BIT];
      end
      rst_pin_o <= !core_reset_o; // active-low reset out
      running_reset_o <= !rst_pin_oe_o && !rst_pin_i;
    end
  end

  // ---------------------------------------------------------------
  // wishbone slave, one wait state
  // ---------------------------------------------------------------
  // ack one cycle after the request is taken, read data with it
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= '0;
    end else begin
      wb_ack_o <= wb_req;
      wb_dat_o <= '0;
      if (wb_req && !wb_we_i) begin
        unique case (wb_adr_i)
          RCS_ADDR_RUNRST: wb_dat_o <= {31'h0, !rst_pin_oe_o};
          RCS_ADDR_PLL: wb_dat_o <= {16'h0, pll_div_o, pll_mul_o};
          RCS_ADDR_STATUS: wb_dat_o <= {25'h0, boot_mode_o,
                                        clk_ratio_strap_i,
                                        state_reg};
          RCS_ADDR_VECTOR: wb_dat_o <= RCS_RESET_VECTOR;
          default: wb_dat_o <= '0;
        endcase
      end
    end
  end

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  sequence lock_wait_s;
    state_reg == RCS_ST_LOCK && !lock_done;
  endsequence
  sequence release_s;
    ##1 !core_reset_o && fetch_start_o;
  endsequence

  // hardware reset and lock wait
  reset_holds_core_a: assert property (@(posedge clk_i)
    !hw_reset_n_i |=> core_reset_o && state_reg == RCS_ST_RESET)
    else $error("core not held in reset");
  counter_clear_a: assert property (@(posedge clk_i)
    in_reset |=> lock_cnt_reg == '0)
    else $error("lock counter not cleared in reset");
  lock_release_a: assert property (
    @(posedge clk_i) disable iff (in_reset)
    state_reg == RCS_ST_LOCK && lock_done |-> release_s)
    else $error("core not released at terminal count");
  lock_wait_a: assert property (@(posedge clk_i) disable iff (in_reset)
    lock_wait_s |=> core_reset_o)
    else $error("core released before lock wait");
  lock_count_a: assert property (
    @(posedge clk_i) disable iff (in_reset)
    lock_wait_s |=> lock_cnt_reg == $past(lock_cnt_reg) + 1'b1)
    else $error("lock counter stalled");
  // vector fetch in the same cycle as release
  vector_fetch_a: assert property (
    @(posedge clk_i) disable iff (in_reset)
    fetch_start_o |-> fetch_addr_o == RCS_RESET_VECTOR)
    else $error("fetch not at reset vector");
  fetch_pulse_a: assert property (
    @(posedge clk_i) disable iff (in_reset)
    fetch_start_o |=> !fetch_start_o)
    else $error("fetch start held longer than one cycle");
  // strap capture
  ratio_decode_a: assert property (@(posedge clk_i)
    !hw_reset_n_i && clk_ratio_strap_i == 2'b01 |=> pll_mul_o == RCS_MUL_32)
    else $error("ratio strap decode wrong");
  boot_capture_a: assert property (@(posedge clk_i)
    !hw_reset_n_i |=> boot_mode_o == $past(boot_mode_strap_i))
    else $error("boot straps not caught in reset");
  // shared reset pin
  pin_default_a: assert property (@(posedge clk_i)
    in_reset |=> rst_pin_oe_o)
    else $error("reset pin not output after reset");
  pin_output_a: assert property (
    @(posedge clk_i) disable iff (in_reset)
    rst_pin_oe_o |=> !running_reset_o)
    else $error("running reset seen while pin is output");
  pin_switch_a: assert property (
    @(posedge clk_i) disable iff (in_reset)
    wr_runrst && wb_dat_i[0] |=> !rst_pin_oe_o)
    else $error("reset pin did not become input");
  run_reset_a: assert property (
    @(posedge clk_i) disable iff (in_reset)
    !rst_pin_oe_o && !rst_pin_i |=> running_reset_o)
    else $error("running reset input not followed");
  // clock reprogramming
  pll_lock_a: assert property (@(posedge clk_i) disable iff (in_reset)
    core_reset_o |=> $stable(pll_mul_o))
    else $error("pll changed before core left reset");
  pll_refuse_a: assert property (
    @(posedge clk_i) disable iff (in_reset)
    wb_req && wb_we_i && wb_adr_i == RCS_ADDR_PLL
      && state_reg != RCS_ST_RUN |=> $stable(pll_div_o))
    else $error("pll divider changed before run");
endmodule // rcs_top

// ---- bench/rcs_board.sv ----
// board reset source, strap pins and pulled-up shared reset pin
`timescale 1ns/10ps
module rcs_board (
  input wire logic clk_i,
  input wire logic rst_req_i,
  input wire logic [1:0] ratio_req_i,
  input wire logic [2:0] boot_req_i,
  input wire logic pull_low_i,
  input wire logic pin_oe_i,
  input wire logic pin_drv_i,
  output logic hw_reset_n_o,
  output logic [1:0] ratio_o,
  output logic [2:0] boot_o,
  output logic pin_o
);
  logic req1_reg = 1'b1;
  logic req2_reg = 1'b1;
  logic [1:0] ratio_reg = 2'h0;
  logic [2:0] boot_reg = 3'h0;
  // straps follow after one edge, reset lags two edges
  always @(posedge clk_i) begin
    ratio_reg <= ratio_req_i;
    boot_reg <= boot_req_i;
    req1_reg <= rst_req_i;
    req2_reg <= req1_reg;
  end
  // straps start at a defined level before the first edge
  assign ratio_o = ratio_reg;
  assign boot_o = boot_reg;
  assign hw_reset_n_o = ~req2_reg;
  // pull-up holds the pin high when nobody drives it
  assign pin_o = pin_oe_i ? pin_drv_i : ~pull_low_i;
endmodule // rcs_board

// ---- bench/tb_top.sv ----
// self-checking bench for reset and clock start-up control
`timescale 1ns/10ps
module tb_top;
  import rcs_pkg::*;
  localparam int L = 16;
  logic clk_i = 0, rst_i = 1, req = 1, low = 0, cyc = 0, stb = 0, we = 0;
  logic [1:0] rat = 2'b00, s_rat;
  logic [2:0] boot = 3'h5, s_boot, bm;
  logic [3:0] adr = 4'h0;
  logic [3:0] sel = 4'hF;
  logic [31:0] dat = 32'h0, q, rd, fa;
  logic hw_n, pin, p_o, p_oe, c_rst, r_rst, fs, ack;
  logic [7:0] mul, dv;
  int err_count = 0, num_checks = 0, tick = 0;
  // free-running reference clock
  always #20 clk_i = ~clk_i;
  rcs_board brd_u (.clk_i(clk_i), .rst_req_i(req), .ratio_req_i(rat),
    .boot_req_i(boot), .pull_low_i(low), .pin_oe_i(p_oe), .pin_drv_i(p_o),
    .hw_reset_n_o(hw_n), .ratio_o(s_rat), .boot_o(s_boot), .pin_o(pin));
  rcs_top #(.LOCK_CYCLES(L)) dut_u (.clk_i(clk_i), .rst_i(rst_i),
    .hw_reset_n_i(hw_n), .clk_ratio_strap_i(s_rat),
    .boot_mode_strap_i(s_boot), .rst_pin_i(pin), .rst_pin_o(p_o),
    .rst_pin_oe_o(p_oe), .core_reset_o(c_rst), .running_reset_o(r_rst),
    .fetch_addr_o(fa), .fetch_start_o(fs), .pll_mul_o(mul),
    .pll_div_o(dv), .boot_mode_o(bm), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat),
    .wb_dat_o(rd), .wb_ack_o(ack));
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    num_checks++;
    if (g !== e) begin
      err_count++;
      $display("unexpected at %0t: got %h want %h", $time, g, e);
    end
  endtask
  // classic single wishbone cycle, held until ack is sampled
  task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d);
    int n = 0;
    cyc <= 1;
    stb <= 1;
    we <= w;
    adr <= a;
    dat <= d;
    do begin
      @(posedge clk_i);
      n++;
    end while (ack !== 1'b1 && n < 20);
    q = rd;
    cyc <= 0;
    stb <= 0;
    chk({31'h0, ack}, 32'h1);
    @(posedge clk_i);
  endtask
  // strap codes 0 to 2: state in reset, lock wait, vector
  task automatic t_boot();
    logic [7:0] tbl [3] = '{RCS_MUL_8, RCS_MUL_32, RCS_MUL_16};
    int n;
    for (int i = 0; i < 3; i++) begin
      rat <= 2'(i);
      boot <= 3'(i + 2);
      req <= 1;
      repeat (5) @(posedge clk_i);
      chk({24'h0, mul}, {24'h0, tbl[i]});
      chk({29'h0, c_rst, p_oe, p_o}, 32'h6);
      chk({29'h0, bm}, 32'(i + 2));
      req <= 0;
      n = 0;
      do begin
        @(posedge clk_i);
        n++;
      end while (fs !== 1'b1 && n < 100);
      chk({31'h0, n >= L + 2 && n <= L + 6}, 32'h1);
      chk(fa, RCS_RESET_VECTOR);
      @(posedge clk_i);
      chk({31'h0, c_rst}, 32'h0);
      chk({30'h0, p_o, fs}, 32'h2);
    end
  endtask
  // clock reprogram refused in lock, taken in run, vector read only
  task automatic t_regs();
    req <= 1;
    repeat (4) @(posedge clk_i);
    req <= 0;
    repeat (3) @(posedge clk_i);
    wb(1, RCS_ADDR_PLL, 32'h0000_0305);
    chk({24'h0, mul}, {24'h0, RCS_MUL_16});
    repeat (L + 4) @(posedge clk_i);
    wb(1, RCS_ADDR_PLL, 32'h0000_030A);
    chk({16'h0, dv, mul}, 32'h0000_030A);
    wb(0, RCS_ADDR_PLL, 32'h0);
    chk(q, 32'h0000_030A);
    wb(1, RCS_ADDR_VECTOR, 32'h1234_5678);
    wb(0, RCS_ADDR_VECTOR, 32'h0);
    chk(q, RCS_RESET_VECTOR);
    wb(0, RCS_ADDR_STATUS, 32'h0);
    chk(q, {25'h0, 3'h4, 2'h2, RCS_ST_RUN});
    // divider byte alone: multiplier must keep its value
    sel <= 4'h2;
    wb(1, RCS_ADDR_PLL, 32'h0000_0577);
    sel <= 4'hF;
    chk({16'h0, dv, mul}, 32'h0000_050A);
  endtask
  // shared pin turned into running-reset input and back
  task automatic t_runrst();
    wb(1, RCS_ADDR_RUNRST, 32'h1);
    chk({31'h0, p_oe}, 32'h0);
    wb(0, RCS_ADDR_RUNRST, 32'h0);
    chk(q, 32'h1);
    low <= 1;
    repeat (3) @(posedge clk_i);
    chk({31'h0, r_rst}, 32'h1);
    low <= 0;
    repeat (3) @(posedge clk_i);
    chk({31'h0, r_rst}, 32'h0);
    wb(1, RCS_ADDR_RUNRST, 32'h0);
    chk({31'h0, p_oe}, 32'h1);
  endtask
  // counts, verdict and end of run
  task automatic summarize();
    $display("checks %0d errors %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  // hang guard
  always @(posedge clk_i) begin
    tick <= tick + 1;
    if (tick == 3000) begin
      err_count++;
      summarize();
    end
  end
  initial begin
    repeat (2) @(posedge clk_i);
    rst_i <= 0;
    t_boot();
    t_regs();
    t_runrst();
    summarize();
  end
endmodule // tb_top
